// ==== dv/hsnme_exec_sva.sv ====
// Checker for the micro executor, bound to its ports.
// Assumes one clock, core_clk, and synchronous active high rst.
`timescale 1ns/1ps
`default_nettype none
module hsnme_exec_sva
    import hsnme_pkg::*;
#(
    parameter int OPERAND_W = 24,
    parameter int COUNT_W   = 16
) (
    // Clock, reset and bus
    input wire logic              core_clk,
    input wire logic              rst,
    input wire hsnme_apb_req_type apb_req,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Execution side
    input wire logic [7:0]        fetch_data,
    input wire logic              micro_fetch,
    input wire logic              micro_finish,
    input wire logic              refresh_request,
    input wire logic              local_memory_write_strobe,
    input wire logic              refresh_grant,
    input wire logic [1:0]        console_select,
    input wire logic [31:0]       console_lamps,
    input wire logic              run_state_flop,
    input wire logic              jump_level,
    input wire logic              repeat_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic pend; // A fetched micro has not finished yet
    // Track a fetch until its micro finishes or running stops
    always_ff @(posedge core_clk) begin
        if (rst || micro_finish || !run_state_flop) begin
            pend <= 1'b0;
        end else if (micro_fetch) begin
            pend <= 1'b1;
        end
    end
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    AST_LEVELS_HELD: assert property (jump_level && repeat_level)
        else $error("jump or repeat level dropped");
    AST_FINISH_PULSE: assert property (micro_finish |=> !micro_finish)
        else $error("finish longer than one cycle");
    AST_ONE_FETCH: assert property (micro_fetch && run_state_flop |-> !pend)
        else $error("second fetch before finish");
    AST_PASS_LOOP: assert property (local_memory_write_strobe |=>
        (!micro_finish && !local_memory_write_strobe)[*2] ##[1:5]
        (micro_finish || local_memory_write_strobe))
        else $error("shift pass length wrong");
    AST_FINISH_TIME: assert property (micro_finish && $past(run_state_flop) |->
        $past(micro_fetch) || $past(micro_fetch, 3) ||
        $past(local_memory_write_strobe, 3) ||
        $past(local_memory_write_strobe, 5))
        else $error("finish at wrong sequencer state");
    AST_REFRESH: assert property (refresh_grant |->
        $past(refresh_request))
        else $error("refresh granted without request");
    AST_RUN_STOP: assert property ($fell(run_state_flop) |->
        micro_finish || $past(apb_req.psel))
        else $error("run flop cleared without cause");
    AST_APB_WAIT: assert property (apb_req.psel && apb_req.penable && !pready
        |=> pready)
        else $error("bus answer late");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    COV_HALT: cover property ($fell(run_state_flop) && micro_finish);
    COV_WB: cover property (local_memory_write_strobe);
    COV_REFRESH: cover property (refresh_grant);
endmodule
bind hsnme_exec hsnme_exec_sva #(
    .OPERAND_W(OPERAND_W),
    .COUNT_W  (COUNT_W)
) u_sva (
    .core_clk(core_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_data(fetch_data),
    .micro_fetch(micro_fetch), .micro_finish(micro_finish),
    .refresh_request(refresh_request), .refresh_grant(refresh_grant),
    .local_memory_write_strobe(local_memory_write_strobe),
    .console_select(console_select), .console_lamps(console_lamps),
    .run_state_flop(run_state_flop), .jump_level(jump_level),
    .repeat_level(repeat_level)
);
`default_nettype wire

// ==== dv/hsnme_exec_tb.sv ====
// Bench for the micro executor with a fetch path model.
// Assumes APB offsets and one-wait-state answers of the executor.
`timescale 1ns/1ps
`default_nettype none
module hsnme_exec_tb
    import hsnme_pkg::*;
;
    logic core_clk, rst, arm, pready, pslverr, micro_fetch, micro_finish;
    logic refresh_request, strobe, refresh_grant, run_state_flop;
    logic jump_level, repeat_level, err, saw_run;
    logic [31:0] prdata, console_lamps, q;
    logic [7:0]  fetch_data, first_op;
    logic [1:0]  console_select;
    hsnme_apb_req_type req; // Bus request
    int n_mismatch, n_checks, cyc, t_fetch, n_fetch1, n_fin, n_str, n_grant;
    int fin_t [2]; // Times of the first two finishes
    hsnme_exec dut (.core_clk(core_clk), .rst(rst), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetch_data(fetch_data), .micro_fetch(micro_fetch),
        .micro_finish(micro_finish), .refresh_request(refresh_request),
        .local_memory_write_strobe(strobe), .refresh_grant(refresh_grant),
        .console_select(console_select), .console_lamps(console_lamps),
        .run_state_flop(run_state_flop), .jump_level(jump_level),
        .repeat_level(repeat_level));
    hsnme_fetch_model u_fetch (.core_clk(core_clk), .rst(rst), .arm(arm),
        .first_op(first_op), .later_op(8'h1f), .micro_fetch(micro_fetch),
        .fetch_data(fetch_data));
    // Clock at 25 MHz
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Log fetches, finishes and strobes of the run in progress
    always @(posedge core_clk) begin
        // Refresh request toggles so grants must follow it
        refresh_request <= rst ? 1'b1 : ~refresh_request;
        cyc++;
        if (arm) begin
            {n_fin, n_str, n_grant, n_fetch1, saw_run, t_fetch} = '0;
        end else begin
            if (saw_run && micro_fetch && n_fin == 0) begin
                n_fetch1++;
                t_fetch = cyc;
            end
            if (saw_run && micro_finish && n_fin < 2) fin_t[n_fin] = cyc;
            if (saw_run && micro_finish) n_fin++;
            if (strobe) n_str++;
            if (refresh_grant) n_grant++;
            // Run seen only from the edge after it rises
            if (run_state_flop) saw_run = 1'b1;
        end
    end
    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge core_clk);
        req <= {1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        q = prdata;
        err = pslverr;
        req <= '0;
        if (pready !== 1'b1) begin
            chk(0, 1);
            summarize;
        end
    endtask
    // Run op, then nxt unless op is halt, then halt; judge timing and results
    task automatic run_micro(input logic [7:0] op, nxt,
        input logic [23:0] opd, input logic [15:0] cnt, input int gap,
        input int n_wb, input logic [23:0] x_opd, input logic [15:0] x_cnt);
        int i;
        @(posedge core_clk);
        first_op <= nxt;
        arm <= 1'b1;
        @(posedge core_clk);
        arm <= 1'b0;
        apb(1'b1, 12'h008, {8'h00, opd});
        apb(1'b1, 12'h00c, {16'h0000, cnt});
        apb(1'b1, 12'h000, {16'h0000, nxt, op});
        for (i = 0; i < 600 && !(saw_run && !run_state_flop && n_fin > 0);
             i++) @(negedge core_clk);
        if (!(saw_run && !run_state_flop && n_fin > 0)) begin
            chk(0, 1);
            summarize;
        end
        chk(fin_t[0] - t_fetch, gap);
        chk(n_fetch1, 1);
        if (op != 8'h1f) chk(fin_t[1] - fin_t[0], 2);
        chk(n_str, n_wb);
        chk(n_grant > 0, n_wb > 0);
        chk({run_state_flop, jump_level, repeat_level}, 3'b011);
        apb(1'b0, 12'h008, '0);
        chk(q, {8'h00, x_opd});
        apb(1'b0, 12'h00c, '0);
        chk(q, {16'h0000, x_cnt});
        apb(1'b0, 12'h010, '0);
        chk(q[7:0], op == 8'h1f ? nxt : 8'h1f);
        repeat (6) @(negedge core_clk);
        chk(console_lamps, {16'h0000, x_cnt});
    endtask
    // Lamp source follows the select register with the switches at zero
    task automatic console_view;
        @(posedge core_clk);
        console_select <= 2'd0;
        apb(1'b1, 12'h014, 32'h00000002);
        repeat (6) @(negedge core_clk);
        chk(console_lamps, 32'h0000001f);
        apb(1'b1, 12'h014, 32'h00000000);
        repeat (6) @(negedge core_clk);
        chk(console_lamps, 32'h00800000);
    endtask
    // Main sequence
    initial begin
        {rst, req, arm, first_op} = '1;
        {req, arm} = '0;
        console_select = 2'd1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h010, '0);
        chk(q, 32'h00000f0f);
        chk({run_state_flop, jump_level, repeat_level}, 3'b011);
        run_micro(8'h1f, 8'h0f, 24'h000001, 16'h0000, 1, 0, 24'h1, 0);
        run_micro(8'h0f, 8'h9d, 24'h000002, 16'h0004, 1, 0, 24'h2, 4);
        run_micro(8'h3f, 8'h0f, 24'h000001, 16'h0000, 1, 0, 24'h1, 0);
        run_micro(8'h3f, 8'h0f, 24'h000001, 16'h0003, 22, 3, 24'h8, 0);
        run_micro(8'h3f, 8'h0f, 24'h200000, 16'h8000, 17, 2, 24'h800000,
                  16'h7ffe);
        run_micro(8'h3f, 8'h9d, 24'h800000, 16'h0005, 3, 0, 24'h800000, 5);
        apb(1'b0, 12'h018, '0);
        chk({31'h00000000, err}, 32'h00000001);
        chk(q, 32'h00000000);
        console_view;
        summarize;
    end
endmodule
`default_nettype wire

// ==== dv/hsnme_fetch_model.sv ====
// Fetch path model: answers each micro fetch with an opcode.
// Assumes the executor samples fetch_data at the edge ending a fetch.
`timescale 1ns/1ps
`default_nettype none
module hsnme_fetch_model (
    // Clock, reset and arming
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       arm,
    // Opcodes for the first and the later fetches
    input  wire logic [7:0] first_op,
    input  wire logic [7:0] later_op,
    // Fetch path
    input  wire logic       micro_fetch,
    output var  logic [7:0] fetch_data
);
    logic       used;  // First fetch already answered
    logic [7:0] noise; // Moving pattern outside a fetch
    // Step to the later opcode after the first fetch
    always_ff @(posedge core_clk) begin
        if (rst || arm) begin
            used <= 1'b0;
        end else if (micro_fetch) begin
            used <= 1'b1;
        end
        noise <= rst ? 8'ha5 : ~noise + 8'h35;
    end
    // Data is only valid while the fetch is in progress
    assign fetch_data = micro_fetch ? (used ? later_op : first_op)
                                    : noise;
endmodule
`default_nettype wire

// ==== logic/hsnme_consts.svh ====
// Constants for the halt, shift and no-op micro executor.
// Assumes inclusion by bare name from the package and the executor.
`ifndef HSNME_CONSTS_SVH
`define HSNME_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HSNME_CTRL_OFF      12'h000
`define HSNME_STATUS_OFF    12'h004
`define HSNME_OPERAND_OFF   12'h008
`define HSNME_FLCOUNT_OFF   12'h00c
`define HSNME_MICRO_OFF     12'h010
`define HSNME_CONSOLE_OFF   12'h014
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HSNME_CTRL_RUN_BIT  0
`define HSNME_CTRL_LOAD_BIT 1
// ----------------------------------------------------------------
// Micro opcodes
// ----------------------------------------------------------------
`define HSNME_OP_HALT       8'h1f
`define HSNME_OP_SHIFT      8'h3f
`define HSNME_OP_NOOP       8'h0f
`define HSNME_OP_MONITOR    8'h9d
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define HSNME_MICRO_RST     8'h0f
`define HSNME_MASK_BITS     23
`define HSNME_PASS_CLOCKS   7
`endif

// ==== logic/hsnme_exec.sv ====
// Executor for the halt, shift-until-one, no-op and monitor micros.
// Assumes an APB master on core_clk and a fetch path answering in S1.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hsnme_consts.svh"

// Contract
// - Halt micro clears run flop at finish
// - Halt keeps jump and repeat levels true
// - Halted processor runs pseudo no-ops for lamps
// - Shift operand left, decrement count each pass
// - Each shifted bit costs seven clocks
// - Finish after 2 clocks or 4 clocks
// - Nonzero count suppresses finish at S1
// - Mask rotated left one zero-fills right
// - Top bit tested at S3 on source
// - Rotated operand written back under write strobe
// - No end: step S0 to S6, repeat
// - Only one micro fetch, first S0/S1
// - Finish loads latched micro, resets sequencer
// - Refresh allowed in S5 and S6
// - No-op idles two clocks then proceeds
// - No-op fetches next micro into latch
// - Monitor micro behaves as no-op
// - Run flop shows whether processor runs
module hsnme_exec
    import hsnme_pkg::*;
#(
    parameter int OPERAND_W = 24,
    parameter int COUNT_W   = 16
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // APB slave
    input  wire hsnme_apb_req_type apb_req,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Micro fetch path
    input  wire logic [7:0]        fetch_data,
    output var  logic              micro_fetch,
    output var  logic              micro_finish,
    // Local memory and refresh
    input  wire logic              refresh_request,
    output var  logic              local_memory_write_strobe,
    output var  logic              refresh_grant,
    // Console and levels
    input  wire logic [1:0]        console_select,
    output var  logic [31:0]       console_lamps,
    output var  logic              run_state_flop,
    output var  logic              jump_level,
    output var  logic              repeat_level
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (OPERAND_W < `HSNME_MASK_BITS + 1 || OPERAND_W > 32 ||
        COUNT_W < 1 || COUNT_W > 32) begin : g_bad
        $error("hsnme_exec: unsupported width");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hsnme_state_type          seq;              // Sequencer state
    hsnme_state_type          next_seq;         // Next sequencer state
    logic [7:0]               micro_ir;         // Micro being executed
    logic [7:0]               next_micro_latch; // Fetched next micro
    logic                     first_pass;       // First pass of micro
    logic [OPERAND_W-1:0]     shift_operand;    // Shift operand word
    logic [COUNT_W-1:0]       field_length_count; // Field length
    logic [OPERAND_W-1:0]     memory_info_register; // Holding register
    logic [OPERAND_W-1:0]     local_write_buffer;   // Write buffer
    logic [OPERAND_W-1:0]     pass_mask;        // Rotated mask
    logic [1:0]               console_sel_reg;  // Software lamp select

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic is_shift = run_state_flop &&
                          micro_ir == `HSNME_OP_SHIFT;
    wire logic is_halt  = run_state_flop &&
                          micro_ir == `HSNME_OP_HALT;
    // Count test uses every bit of the field length
    wire logic count_zero  = field_length_count == '0;
    // Top bit of the unrotated source word
    wire logic operand_top_bit =
        shift_operand[OPERAND_W-1];
    // Shift ends at S1 on zero count, at S3 on top bit
    wire logic shift_finish =
        (seq == SEQ_S1 && count_zero) ||
        (seq == SEQ_S3 && operand_top_bit);
    // Every other micro (and the halted pseudo no-op) ends at S1
    wire logic short_finish = !is_shift && seq == SEQ_S1;
    wire logic finish_now = is_shift ? shift_finish : short_finish;
    // Only the first pass fetches
    wire logic fetch_slot = first_pass && run_state_flop;
    // A fetch landing at a finish edge feeds the micro register directly
    wire logic fetch_take = fetch_slot && seq == SEQ_S1;
    // Write back at the end of a full pass
    wire logic write_back = is_shift && seq == SEQ_S5;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        if (finish_now) begin
            next_seq = SEQ_S0;
        end else begin
            case (seq)
                SEQ_S0:  next_seq = SEQ_S1;
                SEQ_S1:  next_seq = SEQ_S2;
                SEQ_S2:  next_seq = SEQ_S3;
                SEQ_S3:  next_seq = SEQ_S4;
                SEQ_S4:  next_seq = SEQ_S5;
                SEQ_S5:  next_seq = SEQ_S6;
                SEQ_S6:  next_seq = SEQ_S0;
                default: next_seq = SEQ_S0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic apb_access = apb_req.psel && apb_req.penable && !pready;
    // Writes take effect at the edge that completes the transfer
    wire logic apb_wr     = apb_req.psel && apb_req.penable &&
                            pready && apb_req.pwrite;
    wire logic hit_ctrl   = apb_req.paddr == `HSNME_CTRL_OFF;
    wire logic hit_status = apb_req.paddr == `HSNME_STATUS_OFF;
    wire logic hit_oper   = apb_req.paddr == `HSNME_OPERAND_OFF;
    wire logic hit_count  = apb_req.paddr == `HSNME_FLCOUNT_OFF;
    wire logic hit_micro  = apb_req.paddr == `HSNME_MICRO_OFF;
    wire logic hit_cons   = apb_req.paddr == `HSNME_CONSOLE_OFF;
    wire logic hit_any    = hit_ctrl | hit_status | hit_oper |
                            hit_count | hit_micro | hit_cons;
    wire logic wr_run  = apb_wr && hit_ctrl &&
                         apb_req.pwdata[`HSNME_CTRL_RUN_BIT];
    wire logic wr_stop = apb_wr && hit_ctrl &&
                         !apb_req.pwdata[`HSNME_CTRL_RUN_BIT];
    wire logic wr_load = apb_wr && hit_ctrl &&
                         apb_req.pwdata[`HSNME_CTRL_LOAD_BIT];
    wire logic [31:0] status_word = {24'h000000, first_pass,
                                     seq, 3'h0, run_state_flop};
    wire logic [31:0] read_word =
        hit_ctrl   ? {31'h00000000, run_state_flop} :
        hit_status ? status_word :
        hit_oper   ? 32'(shift_operand) :
        hit_count  ? 32'(field_length_count) :
        hit_micro  ? {16'h0000, next_micro_latch, micro_ir} :
        hit_cons   ? {30'h00000000, console_sel_reg} : 32'h00000000;

    // ------------------------------------------------------------
    // Rotated mask and shifted operand
    // ------------------------------------------------------------
    // Mask of low ones rotated left one leaves bit 0 clear
    assign pass_mask = OPERAND_W'({{(OPERAND_W-`HSNME_MASK_BITS){1'b0}},
                       {`HSNME_MASK_BITS{1'b1}}} << 1);
    wire logic [OPERAND_W-1:0] rotated_operand =
        {shift_operand[OPERAND_W-2:0], shift_operand[OPERAND_W-1]};

    // Lamp source chosen by console switches or software
    wire logic [1:0] lamp_sel = console_select | console_sel_reg;
    wire logic [31:0] lamp_word =
        lamp_sel == 2'h0 ? 32'(shift_operand) :
        lamp_sel == 2'h1 ? 32'(field_length_count) :
        lamp_sel == 2'h2 ? {24'h000000, micro_ir} : status_word;

    // ------------------------------------------------------------
    // APB answer: one wait state, error on unmapped address
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_access;
            pslverr <= apb_access && !hit_any;
            prdata  <= (apb_access && !apb_req.pwrite) ? read_word
                                                       : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Sequencer, micro register and fetch
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq              <= SEQ_S0;
            micro_ir         <= `HSNME_MICRO_RST;
            next_micro_latch <= `HSNME_MICRO_RST;
            first_pass       <= 1'b1;
            micro_fetch      <= 1'b0;
            micro_finish     <= 1'b0;
        end else begin
            // Halted: pseudo no-op loop keeps cycling S0 and S1
            // A loaded micro starts at S0 so its one fetch is made
            seq          <= wr_load ? SEQ_S0 : next_seq;
            micro_finish <= finish_now;
            // Fetch request raised leaving S0, held through S1, of the first pass only
            micro_fetch  <= fetch_slot && next_seq == SEQ_S1 &&
                            !finish_now;
            if (fetch_take) begin
                next_micro_latch <= fetch_data;
            end else if (wr_load) begin
                next_micro_latch <= apb_req.pwdata[15:8];
            end
            if (finish_now && run_state_flop) begin
                // Latched micro runs next (monitor decodes as no-op)
                micro_ir   <= fetch_take ? fetch_data
                                         : next_micro_latch;
                first_pass <= 1'b1;
            end else if (wr_load) begin
                micro_ir   <= apb_req.pwdata[7:0];
                first_pass <= 1'b1;
            end else if (seq == SEQ_S6) begin
                first_pass <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Run state flop and held levels
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_state_flop <= 1'b0;
            jump_level     <= 1'b1;
            repeat_level   <= 1'b1;
        end else begin
            // Software start wins over a halt finishing
            if (wr_run) begin
                run_state_flop <= 1'b1;
            end else if (wr_stop || (is_halt && finish_now)) begin
                run_state_flop <= 1'b0;
            end
            // Halt leaves both levels alone
            jump_level   <= jump_level;
            repeat_level <= repeat_level;
        end
    end

    // ------------------------------------------------------------
    // Shift data path and local memory writeback
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_operand             <= '0;
            field_length_count        <= '0;
            memory_info_register      <= '0;
            local_write_buffer        <= '0;
            local_memory_write_strobe <= 1'b0;
        end else begin
            // Holding register takes the masked rotated operand
            if (is_shift && seq == SEQ_S2) begin
                memory_info_register <= rotated_operand & pass_mask;
            end
            // Holding register moves to the write buffer
            if (is_shift && seq == SEQ_S4) begin
                local_write_buffer <= memory_info_register;
            end
            local_memory_write_strobe <= write_back;
            if (write_back) begin
                shift_operand      <= local_write_buffer;
                field_length_count <= field_length_count -
                                      COUNT_W'(1);
            end else begin
                if (apb_wr && hit_oper) begin
                    shift_operand <= apb_req.pwdata[OPERAND_W-1:0];
                end
                if (apb_wr && hit_count) begin
                    field_length_count <= apb_req.pwdata[COUNT_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Refresh window, console lamps and lamp select
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            refresh_grant   <= 1'b0;
            console_lamps   <= 32'h00000000;
            console_sel_reg <= 2'h0;
        end else begin
            // Grant only inside S5/S6 of a shift pass
            refresh_grant <= refresh_request && is_shift &&
                             (next_seq == SEQ_S5 ||
                              next_seq == SEQ_S6);
            // Lamps refresh on each halted pseudo no-op
            if (!run_state_flop && seq == SEQ_S1) begin
                console_lamps <= lamp_word;
            end
            if (apb_wr && hit_cons) begin
                console_sel_reg <= apb_req.pwdata[1:0];
            end
        end
    end
    // Pass length is fixed by the S0..S6 loop
endmodule
`default_nettype wire

// ==== logic/hsnme_pkg.sv ====
// Types shared by the micro executor and its bench.
// Assumes the constants header sits beside it.
`include "hsnme_consts.svh"
package hsnme_pkg;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_S0, SEQ_S1, SEQ_S2, SEQ_S3, SEQ_S4, SEQ_S5, SEQ_S6
    } hsnme_state_type;
    // ------------------------------------------------------------
    // APB request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } hsnme_apb_req_type;
endpackage
